//--- src/mrsg_pkg.sv
package mrsg_pkg;
   localparam int ADDR_W = 10;
   localparam int WORD_DIGITS = 40;
   localparam int FIELD_DIGITS = 10;
   localparam int ORDER_W = 20;

   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_ORDER = 8'h04;
   localparam logic [7:0] OFF_CTRCNT = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0C;
   localparam logic [7:0] OFF_DISPATCH = 8'h10;

   // control, order, dispatch and status register fields
   localparam int CTRL_FETCH_A = 0;
   localparam int CTRL_FETCH_B = 1;
   localparam int CTRL_FETCH_C = 2;
   localparam int CTRL_OPERATE = 3;
   localparam int CTRL_DIRECT = 4;
   localparam int CTRL_ORDER_LSB = 8;
   localparam int ORDER_ADDR_LSB = 10;
   localparam int DISP_REGEN_LSB = 16;
   localparam int STAT_DISP_LSB = 16;

   // chassis group bases
   localparam int OUTER_LO_BASE = 0;
   localparam int LOW_BASE = 10;
   localparam int OUTER_HI_BASE = 20;
   localparam int HIGH_BASE = 30;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;
   localparam logic [31:0] REG_RESET = 32'h0000_0000;

   typedef enum logic [3:0] {
      ORD_NONE = 4'h0,
      ORD_MOVE = 4'h1,
      ORD_HALT = 4'h2,
      ORD_JUMP = 4'h3,
      ORD_JUMP_ALT = 4'h4,
      ORD_STORE_FULL = 4'h5,
      ORD_STORE_LOW = 4'h6,
      ORD_STORE_HIGH = 4'h7
   } mrsg_order_e;

   // gray along regen -> action -> done
   typedef enum logic [1:0] {
      SYNC_REGEN = 2'h0,
      SYNC_ACTION = 2'h1,
      SYNC_DONE = 2'h3
   } mrsg_sync_e;

   typedef struct packed {
      logic counterRequest;
      logic writeOperationFlag;
      logic fullStore;
      logic upperTerm;
      logic lowerTerm;
   } mrsg_decode_s;

   typedef struct packed {
      logic memRequest;
      logic selOrderReg;
      logic selCounter;
      logic readRegen;
      logic writeOuter;
      logic writeLow;
      logic writeHigh;
      logic haveUsedMemory;
      logic [ADDR_W-1:0] address;
      logic [WORD_DIGITS-1:0] chassisWrite;
      logic [WORD_DIGITS-1:0] writeData;
   } mrsg_mem_s;
endpackage

//--- src/mrsg_order_decode.sv
`timescale 1ns/1ps
module mrsg_order_decode
(
   input wire logic [3:0] orderCode,
   input wire logic operate,
   output mrsg_pkg::mrsg_decode_s dec
);
   logic operandMoveOrderActive;
   logic haltOrderActive;
   logic jumpActive;
   logic fullActive;
   logic lowActive;
   logic highActive;

   // every decode is qualified by the operate phase
   always_comb
   begin
      operandMoveOrderActive = operate && (orderCode == mrsg_pkg::ORD_MOVE);
      haltOrderActive = operate && (orderCode == mrsg_pkg::ORD_HALT);
      jumpActive = operate && ((orderCode == mrsg_pkg::ORD_JUMP) ||
                               (orderCode == mrsg_pkg::ORD_JUMP_ALT));
      fullActive = operate && (orderCode == mrsg_pkg::ORD_STORE_FULL);
      lowActive = operate && (orderCode == mrsg_pkg::ORD_STORE_LOW);
      highActive = operate && (orderCode == mrsg_pkg::ORD_STORE_HIGH);
      dec.counterRequest = operandMoveOrderActive || haltOrderActive || jumpActive;
      dec.writeOperationFlag = fullActive || lowActive || highActive;
      dec.fullStore = fullActive;
      dec.upperTerm = fullActive || highActive;
      dec.lowerTerm = fullActive || lowActive;
   end
endmodule

//--- src/mrsg_top.sv
`timescale 1ns/1ps
module mrsg_top
(
   input wire logic clk,
   input wire logic rst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // memory side
   input wire logic actionSense,
   input wire logic [mrsg_pkg::WORD_DIGITS-1:0] accWord,
   output mrsg_pkg::mrsg_mem_s mem
);
   typedef struct packed {
      logic direct;
      logic fetch;
      logic counter;
      logic writeOp;
      logic full;
      logic upper;
      logic lower;
      logic [mrsg_pkg::ADDR_W-1:0] ordAddr;
   } mrsg_latch_s;

   typedef struct packed {
      logic [31:0] ctrl;
      logic [mrsg_pkg::ORDER_W-1:0] ord;
      logic [mrsg_pkg::ADDR_W-1:0] ctrAddr;
      logic [mrsg_pkg::ADDR_W-1:0] regenAddr;
      logic [mrsg_pkg::ADDR_W-1:0] dispatch;
      mrsg_pkg::mrsg_sync_e sync;
      mrsg_latch_s lat;
      logic pendWrite;
      logic [7:0] busAddr;
      logic [31:0] rdata;
      logic readyOut;
      mrsg_pkg::mrsg_mem_s mem;
   } mrsg_state_s;

   mrsg_state_s s;
   mrsg_state_s next_;
   mrsg_pkg::mrsg_decode_s dec;
   logic fetchPair;
   logic direct;
   logic orderDrivenMemoryRequest;
   logic memReq;
   logic startAction;
   logic actionNext;
   logic take;

   // spread the three group strobes over the forty chassis lines
   function automatic logic [mrsg_pkg::WORD_DIGITS-1:0] spreadStrobes(
      input logic outer,
      input logic low,
      input logic high
   );
      logic [mrsg_pkg::WORD_DIGITS-1:0] v;
      v = '0;
      for (int i = 0; i < mrsg_pkg::FIELD_DIGITS; i++)
      begin
         v[mrsg_pkg::OUTER_LO_BASE + i] = outer;
         v[mrsg_pkg::LOW_BASE + i] = low;
         v[mrsg_pkg::OUTER_HI_BASE + i] = outer;
         v[mrsg_pkg::HIGH_BASE + i] = high;
      end
      return v;
   endfunction

   // one counter step; wraps at the top like the half-adder chain
   function automatic logic [mrsg_pkg::ADDR_W-1:0] nextAddr(
      input logic [mrsg_pkg::ADDR_W-1:0] a
   );
      return a + {{(mrsg_pkg::ADDR_W-1){1'b0}}, 1'b1};
   endfunction

   // register read mux; unmapped words read zero
   function automatic logic [31:0] readReg(
      input logic [7:0] a,
      input mrsg_state_s st
   );
      logic [31:0] r;
      r = '0;
      unique case (a)
         mrsg_pkg::OFF_CTRL: r = st.ctrl;
         mrsg_pkg::OFF_ORDER: r[mrsg_pkg::ORDER_W-1:0] = st.ord;
         mrsg_pkg::OFF_CTRCNT: r[mrsg_pkg::ADDR_W-1:0] = st.ctrAddr;
         mrsg_pkg::OFF_STATUS:
         begin
            r[0] = st.mem.memRequest;
            r[1] = (st.sync == mrsg_pkg::SYNC_ACTION);
            r[2] = st.mem.haveUsedMemory;
            r[3] = st.mem.selOrderReg;
            r[4] = st.mem.readRegen;
            r[5] = st.mem.writeOuter;
            r[6] = st.mem.writeLow;
            r[7] = st.mem.writeHigh;
            r[mrsg_pkg::STAT_DISP_LSB +: mrsg_pkg::ADDR_W] = st.mem.address;
         end
         mrsg_pkg::OFF_DISPATCH:
         begin
            r[mrsg_pkg::ADDR_W-1:0] = st.dispatch;
            r[mrsg_pkg::DISP_REGEN_LSB +: mrsg_pkg::ADDR_W] = st.regenAddr;
         end
         default: r = '0;
      endcase
      return r;
   endfunction

   mrsg_order_decode u_decode
   (
      .orderCode(s.ctrl[mrsg_pkg::CTRL_ORDER_LSB +: 4]),
      .operate(s.ctrl[mrsg_pkg::CTRL_OPERATE]),
      .dec(dec)
   );

   // request sources
   always_comb
   begin
      fetchPair = !s.ctrl[mrsg_pkg::CTRL_FETCH_A] && s.ctrl[mrsg_pkg::CTRL_FETCH_B] &&
                  s.ctrl[mrsg_pkg::CTRL_FETCH_C];
      direct = s.ctrl[mrsg_pkg::CTRL_DIRECT];
      orderDrivenMemoryRequest = direct || dec.counterRequest;
      memReq = fetchPair || orderDrivenMemoryRequest;
      startAction = (s.sync == mrsg_pkg::SYNC_REGEN) && actionSense && memReq;
      take = hsel && hready && ((htrans == mrsg_pkg::HTRANS_NONSEQ) ||
                                (htrans == mrsg_pkg::HTRANS_SEQ));
   end

   // whole next state: bus, sync sequencing, dispatch counting, outputs
   always_comb
   begin
      next_ = s;
      actionNext = 1'b0;

      // write data phase lands one cycle after the address phase
      if (s.pendWrite)
      begin
         unique case (s.busAddr)
            mrsg_pkg::OFF_CTRL: next_.ctrl = hwdata;
            mrsg_pkg::OFF_ORDER: next_.ord = hwdata[mrsg_pkg::ORDER_W-1:0];
            mrsg_pkg::OFF_CTRCNT: next_.ctrAddr = hwdata[mrsg_pkg::ADDR_W-1:0];
            default: ;
         endcase
      end
      next_.pendWrite = take && hwrite;
      next_.busAddr = haddr[7:0];
      next_.readyOut = 1'b1;
      if (take && !hwrite)
         next_.rdata = readReg(haddr[7:0], s);

      // sync sequence; the done state blocks a new start until the request drops
      unique case (s.sync)
         mrsg_pkg::SYNC_REGEN:
         begin
            if (startAction)
            begin
               next_.sync = mrsg_pkg::SYNC_ACTION;
               // latch all decode so nothing moves while the beam is on
               next_.lat.fetch = fetchPair;
               next_.lat.direct = direct && !fetchPair;
               next_.lat.counter = dec.counterRequest && !fetchPair;
               next_.lat.writeOp = dec.writeOperationFlag && !fetchPair;
               next_.lat.full = dec.fullStore && !fetchPair;
               next_.lat.upper = dec.upperTerm && !fetchPair;
               next_.lat.lower = dec.lowerTerm && !fetchPair;
               next_.lat.ordAddr = s.ord[mrsg_pkg::ORDER_ADDR_LSB +: mrsg_pkg::ADDR_W];
            end
         end
         mrsg_pkg::SYNC_ACTION:
         begin
            if (actionSense)
               next_.sync = mrsg_pkg::SYNC_DONE;
         end
         mrsg_pkg::SYNC_DONE:
         begin
            if (!memReq)
               next_.sync = mrsg_pkg::SYNC_REGEN;
         end
         default: next_.sync = mrsg_pkg::SYNC_REGEN;
      endcase

      // dispatch register loads at each sense pulse except when a direct action starts without the fetch pair, one shared ten-bit register
      if (actionSense)
      begin
         if (startAction && fetchPair)
         begin
            next_.dispatch = s.ctrAddr;
            next_.ctrAddr = nextAddr(s.ctrAddr);
         end
         else if (!(startAction && direct))
         begin
            // regen cycles and counter-request actions both advance regeneration
            next_.dispatch = s.regenAddr;
            next_.regenAddr = nextAddr(s.regenAddr);
         end
      end

      actionNext = (next_.sync == mrsg_pkg::SYNC_ACTION);

      // memory outputs, registered; selects, address and strobes taken from the next state so they stay coherent
      next_.mem.memRequest = memReq;
      next_.mem.selOrderReg = actionNext && next_.lat.direct;
      next_.mem.selCounter = !(actionNext && next_.lat.direct);
      next_.mem.address = next_.mem.selOrderReg ? next_.lat.ordAddr : next_.dispatch;
      next_.mem.readRegen = !(next_.lat.writeOp && actionNext);
      next_.mem.writeOuter = actionNext && next_.lat.full;
      next_.mem.writeLow = actionNext && next_.lat.lower;
      next_.mem.writeHigh = actionNext && next_.lat.upper;
      next_.mem.chassisWrite = spreadStrobes(next_.mem.writeOuter, next_.mem.writeLow,
                                             next_.mem.writeHigh);
      next_.mem.writeData = accWord;
      next_.mem.haveUsedMemory = (next_.sync == mrsg_pkg::SYNC_DONE);
   end

   // single state register, synchronous reset
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s <= '0;
         s.ctrl <= mrsg_pkg::REG_RESET;
         s.sync <= mrsg_pkg::SYNC_REGEN;
         s.readyOut <= 1'b1;
         s.mem.readRegen <= 1'b1;
         s.mem.selCounter <= 1'b1;
      end
      else
         s <= next_;
   end

   // outputs straight from the state register; always OKAY
   assign hreadyout = s.readyOut;
   assign hresp = 1'b0;
   assign hrdata = s.rdata;
   assign mem = s.mem;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_fetch_request: assert property (
      fetchPair |=> mem.memRequest)
      else $error("fetch pair flags did not raise the memory request");

   a_counter_request: assert property (
      s.ctrl[mrsg_pkg::CTRL_OPERATE] &&
      (s.ctrl[mrsg_pkg::CTRL_ORDER_LSB +: 4] == mrsg_pkg::ORD_HALT) |=> mem.memRequest)
      else $error("halt order in operate phase gave no request");

   a_order_request: assert property (
      !fetchPair && !orderDrivenMemoryRequest |=> !mem.memRequest)
      else $error("request raised with no source");

   a_addr_select: assert property (
      mem.selOrderReg |-> mem.address == s.lat.ordAddr)
      else $error("order address not presented while order register selected");

   a_select_inverse: assert property (
      mem.selCounter != mem.selOrderReg)
      else $error("select lines not complementary");

   a_regen_advance: assert property (
      (s.sync == mrsg_pkg::SYNC_REGEN) && actionSense && !memReq
      |=> (s.dispatch == $past(s.regenAddr)) &&
          (s.regenAddr == $past(s.regenAddr) + 10'h001))
      else $error("regeneration address did not advance");

   a_fetch_address: assert property (
      startAction && fetchPair |=> mem.address == $past(s.ctrAddr) [*1])
      else $error("fetch action did not show the control counter");

   a_read_regen: assert property (
      !mem.readRegen |-> (s.sync == mrsg_pkg::SYNC_ACTION) && s.lat.writeOp)
      else $error("read line dropped outside a store action");

   a_outer_full: assert property (
      mem.writeOuter |-> mem.writeLow && mem.writeHigh && s.lat.full)
      else $error("outer strobe without full-word store");

   a_field_strobe: assert property (
      mem.writeLow || mem.writeHigh |-> (s.sync == mrsg_pkg::SYNC_ACTION))
      else $error("field strobe outside an action cycle");

   a_action_hold: assert property (
      (s.sync == mrsg_pkg::SYNC_ACTION) && actionSense |=>
      (s.sync == mrsg_pkg::SYNC_DONE) && mem.haveUsedMemory)
      else $error("action cycle did not end on the sense pulse");

   a_stable_action: assert property (
      (s.sync == mrsg_pkg::SYNC_ACTION) && $past(s.sync == mrsg_pkg::SYNC_ACTION)
      |-> $stable(mem.address) && $stable(mem.chassisWrite) && $stable(mem.selOrderReg))
      else $error("address or strobes moved inside an action cycle");

   a_regen_address: assert property (
      (s.sync == mrsg_pkg::SYNC_REGEN) && actionSense && !startAction
      |=> mem.address == $past(s.regenAddr))
      else $error("regeneration cycle did not show the regeneration address");

   a_dispatch_shared: assert property (
      !mem.selOrderReg |-> mem.address == s.dispatch)
      else $error("address generator saw something other than the dispatch register");

   a_write_only_store: assert property (
      mem.writeOuter || mem.writeLow || mem.writeHigh |-> !mem.readRegen)
      else $error("write strobe outside a store action");

   a_chassis_spread: assert property (
      mem.chassisWrite == {{mrsg_pkg::FIELD_DIGITS{mem.writeHigh}},
                           {mrsg_pkg::FIELD_DIGITS{mem.writeOuter}},
                           {mrsg_pkg::FIELD_DIGITS{mem.writeLow}},
                           {mrsg_pkg::FIELD_DIGITS{mem.writeOuter}}})
      else $error("chassis strobes do not match the group strobes");

   a_high_strobe: assert property (
      mem.writeHigh |-> (s.sync == mrsg_pkg::SYNC_ACTION) && s.lat.upper)
      else $error("high-field strobe without a full or upper store action");

   a_write_data: assert property (
      !$past(rst) |-> mem.writeData == $past(accWord))
      else $error("write data does not follow the accumulator");

   a_single_field: assert property (
      mem.writeHigh && !mem.writeOuter |-> !mem.writeLow)
      else $error("field store strobed both field groups");

   a_select_action: assert property (
      mem.selOrderReg |-> (s.sync == mrsg_pkg::SYNC_ACTION) && s.lat.direct)
      else $error("order register selected outside a direct action");

   a_done_hold: assert property (
      (s.sync == mrsg_pkg::SYNC_DONE) && memReq |=> (s.sync == mrsg_pkg::SYNC_DONE))
      else $error("completed action released while the request stood");

   a_counter_regen: assert property (
      startAction && !fetchPair && !direct
      |=> s.regenAddr == $past(s.regenAddr) + 10'h001)
      else $error("counter-request action stopped regeneration");

   c_fetch_cycle: cover property (startAction && fetchPair);
   c_full_store: cover property (mem.writeOuter);
   c_counter_action: cover property (startAction && dec.counterRequest && !direct);
   c_done_release: cover property (mem.haveUsedMemory ##1 !mem.haveUsedMemory);
   c_field_store: cover property (mem.writeLow && !mem.writeOuter);
endmodule

//--- testbench/mrsg_mem_model.sv
`timescale 1ns/1ps
module mrsg_mem_model
#(
   parameter int PERIOD = 12
)
(
   input wire logic clk,
   input wire logic rst,
   input mrsg_pkg::mrsg_mem_s mem,
   output logic actionSense,
   output logic inAction,
   output logic [39:0] stored
);
   int phase;
   // sense pulse once per period; runs free, as the memory never stops cycling
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         phase <= 0;
         actionSense <= 1'b0;
         inAction <= 1'b0;
         stored <= 40'h00_0000_0000;
      end
      else
      begin
         phase <= (phase == PERIOD - 1) ? 0 : phase + 1;
         actionSense <= (phase == PERIOD - 1);
         // action flip on sense; a spent request must not start a new one
         if (actionSense)
            inAction <= inAction ? 1'b0 : (mem.memRequest && !mem.haveUsedMemory);
         // each chassis takes only the digits whose own strobe fired
         stored <= (stored & ~mem.chassisWrite) | (mem.writeData & mem.chassisWrite);
      end
   end
endmodule

//--- testbench/tb_memory_request_and_strobe_gen.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
   $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb_memory_request_and_strobe_gen;
   typedef struct packed {
      logic [11:0] ctrl;
      logic req;
      logic sel;
      logic rr;
      logic wo;
      logic wl;
      logic wh;
   } mrsg_row_s;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic hready;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic actionSense;
   logic inAction;
   logic [39:0] accWord = 40'h00_0000_0000;
   logic [39:0] stored;
   logic [39:0] expMem = 40'h00_0000_0000;
   logic [39:0] acc;
   logic [39:0] m;
   logic [31:0] rdv;
   logic [9:0] a0;
   logic seen;
   mrsg_pkg::mrsg_mem_s mem;
   mrsg_row_s rows [0:11];
   mrsg_row_s r;
   int n_errors = 0;
   int checked = 0;
   int cycles = 0;

   assign hready = hreadyout;
   always #5 clk = ~clk;

   mrsg_top uut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .actionSense(actionSense),
      .accWord(accWord), .mem(mem));
   mrsg_mem_model #(.PERIOD(12)) memModel (.clk(clk), .rst(rst), .mem(mem),
      .actionSense(actionSense), .inAction(inAction), .stored(stored));

   task automatic conclude();
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // one single word transfer; hold each phase until hready is seen high
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= mrsg_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rdv = hrdata;
   endtask

   task automatic syncSense();
      @(posedge clk);
      while (actionSense !== 1'b1) @(posedge clk);
   endtask

   // bounded wait for the memory to enter or leave an action cycle
   task automatic waitAct(input logic v);
      int n;
      n = 0;
      while (inAction !== v && n < 40)
      begin
         @(posedge clk);
         n++;
      end
      `CHK("inAction", v, inAction)
      @(posedge clk);
   endtask

   function automatic logic [39:0] maskOf(input logic wo, input logic wl, input logic wh);
      return {{10{wh}}, {10{wo}}, {10{wl}}, {10{wo}}};
   endfunction

   // cut a hang short
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_errors++;
         conclude();
      end
   end

   initial
   begin
      rows = '{'{12'h006, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0},
         '{12'h108, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0},
         '{12'h208, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0},
         '{12'h308, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0},
         '{12'h408, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0},
         '{12'h518, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1},
         '{12'h618, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0},
         '{12'h718, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1},
         '{12'h010, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0},
         '{12'h100, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0},
         '{12'h007, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0},
         '{12'h500, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0}};
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      `CHK("hreadyout", 1'b1, hreadyout)
      `CHK("readRegen", 1'b1, mem.readRegen)
      `CHK("selCounter", 1'b1, mem.selCounter)
      `CHK("memRequest", 1'b0, mem.memRequest)
      // every order kind, fetch flags and the no-request cases
      for (int i = 0; i < 12; i++)
      begin
         r = rows[i];
         acc = {8'h3C ^ 8'(i), 32'h5A5A_A5A5};
         accWord <= acc;
         ahb(1'b1, 32'(mrsg_pkg::OFF_ORDER), 32'(i + 1) << 10);
         ahb(1'b1, 32'(mrsg_pkg::OFF_CTRCNT), 32'h0000_0200 + 32'(i));
         syncSense();
         ahb(1'b1, 32'(mrsg_pkg::OFF_CTRL), {20'h00000, r.ctrl});
         repeat (2) @(posedge clk);
         `CHK("memRequest", r.req, mem.memRequest)
         if (r.req)
         begin
            waitAct(1'b1);
            m = maskOf(r.wo, r.wl, r.wh);
            `CHK("selOrderReg", r.sel, mem.selOrderReg)
            `CHK("selCounter", !r.sel, mem.selCounter)
            `CHK("readRegen", r.rr, mem.readRegen)
            `CHK("writeOuter", r.wo, mem.writeOuter)
            `CHK("writeLow", r.wl, mem.writeLow)
            `CHK("writeHigh", r.wh, mem.writeHigh)
            `CHK("chassisWrite", m, mem.chassisWrite)
            if (r.sel)
               `CHK("address", 10'(i + 1), mem.address)
            if (i == 0)
               `CHK("address", 10'h200, mem.address)
            waitAct(1'b0);
            `CHK("readRegen", 1'b1, mem.readRegen)
            `CHK("chassisWrite", 40'h00_0000_0000, mem.chassisWrite)
            `CHK("haveUsed", 1'b1, mem.haveUsedMemory)
            expMem = (expMem & ~m) | (acc & m);
         end
         ahb(1'b1, 32'(mrsg_pkg::OFF_CTRL), 32'h0000_0000);
         repeat (3) @(posedge clk);
         `CHK("haveUsed", 1'b0, mem.haveUsedMemory)
         `CHK("stored", expMem, stored)
      end
      // a mapped read first, so the unmapped read must really clear hrdata
      ahb(1'b0, 32'(mrsg_pkg::OFF_ORDER), 32'h0000_0000);
      `CHK("order", 32'h0000_3000, rdv)
      ahb(1'b0, 32'h0000_0020, 32'h0000_0000);
      `CHK("unmapped", 32'h0000_0000, rdv)
      `CHK("hresp", 1'b0, hresp)
      // regeneration keeps stepping, also through a counter-request action
      ahb(1'b1, 32'(mrsg_pkg::OFF_CTRL), 32'h0000_0108);
      syncSense();
      repeat (2) @(posedge clk);
      a0 = mem.address;
      for (int k = 1; k < 4; k++)
      begin
         syncSense();
         repeat (2) @(posedge clk);
         `CHK("regenAddr", a0 + 10'(k), mem.address)
      end
      ahb(1'b1, 32'(mrsg_pkg::OFF_CTRL), 32'h0000_0000);
      // strobes and select latched even when the request is withdrawn mid-action
      syncSense();
      ahb(1'b1, 32'(mrsg_pkg::OFF_CTRL), 32'h0000_0518);
      waitAct(1'b1);
      ahb(1'b1, 32'(mrsg_pkg::OFF_CTRL), 32'h0000_0000);
      repeat (2) @(posedge clk);
      `CHK("chassisWrite", 40'hFF_FFFF_FFFF, mem.chassisWrite)
      `CHK("selOrderReg", 1'b1, mem.selOrderReg)
      waitAct(1'b0);
      // held request after completion must not start a second action
      syncSense();
      ahb(1'b1, 32'(mrsg_pkg::OFF_CTRL), 32'h0000_0010);
      waitAct(1'b1);
      waitAct(1'b0);
      seen = 1'b0;
      repeat (36)
      begin
         @(posedge clk);
         seen = seen | mem.selOrderReg;
      end
      `CHK("restart", 1'b0, seen)
      `CHK("haveUsed", 1'b1, mem.haveUsedMemory)
      // reset in mid-run while a spent request still stands
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK("haveUsed", 1'b0, mem.haveUsedMemory)
      `CHK("memRequest", 1'b0, mem.memRequest)
      `CHK("readRegen", 1'b1, mem.readRegen)
      `CHK("selCounter", 1'b1, mem.selCounter)
      ahb(1'b0, 32'(mrsg_pkg::OFF_CTRL), 32'h0000_0000);
      `CHK("ctrl", 32'h0000_0000, rdv)
      conclude();
   end
endmodule
